// file: video_overlay_cfg.svh
// Purpose: offsets, field positions, reset values and presets
// Assumes: included by its bare name
// Notes: definitions only
`ifndef VIDEO_OVERLAY_CFG_SVH
`define VIDEO_OVERLAY_CFG_SVH
// register byte offsets
`define OFS_SEC_KEY 12'h264
`define OFS_PRETHR 12'h268
`define OFS_W1_COUNT 12'h26c
`define OFS_ICON_TRANSP 12'h270
`define OFS_ICON_INV 12'h274
`define OFS_DEPTH_THR 12'h278
`define OFS_W3_COUNT 12'h27c
`define OFS_PRI_KEY 12'h280
`define OFS_CSC_A 12'h284
`define OFS_CSC_B 12'h288
`define OFS_STATUS 12'h3f0
`define NUM_REGS 10
// writable bit masks, others read zero
`define MASK_SEC_KEY 32'hffffffff
`define MASK_PRETHR 32'h007f00ff
`define MASK_COUNT 32'h0c000fff
`define MASK_ICON 32'h3fffffff
`define MASK_DEPTH_THR 32'h7f7fffff
`define MASK_PRI_KEY 32'h60ffffff
`define MASK_CSC_A 32'hdf3f3fff
`define MASK_CSC_B 32'h1f1f3f3f
`define RESET_VALUE 32'h00000000
// shared field positions
`define KEY_EN_BIT 30
`define KEY_INV_BIT 29
`define SKEY_HI_BIT 31
`define CSC_SD_BIT 31
`define CSC_HD_BIT 30
// compare masks per colour depth
`define CMP_MASK_30 30'h3fffffff
`define CMP_MASK_32 30'h00ffffff
`define CMP_MASK_565 30'h0000ffff
`define CMP_MASK_555 30'h00007fff
`define CMP_MASK_8 30'h000000ff
// bytes per fifo level, as a shift
`define LEVEL_SHIFT 4
// preset coefficient images (control a, control b)
`define CSC_SD_IMG_A 32'h13000ded
`define CSC_SD_IMG_B 32'h13161000
`define CSC_HD_IMG_A 32'h13000eed
`define CSC_HD_IMG_B 32'h12141100
`endif

// file: video_overlay_pkg.sv
// Purpose: shared types of the overlay register bank
// Assumes: nothing
// Notes: constants live in video_overlay_cfg.svh
package video_overlay_pkg;
    typedef enum logic [2:0] {
        GM_256 = 3'h0,
        GM_555 = 3'h1,
        GM_565 = 3'h3,
        GM_32 = 3'h2,
        GM_30 = 3'h6
    } gfx_mode_t;
    typedef enum logic {
        BUS_IDLE = 1'b0,
        BUS_ACK = 1'b1
    } bus_state_t;
    typedef struct packed {
        logic [7:0] y;
        logic signed [7:0] cb;
        logic signed [7:0] cr;
    } ycc_t;
    typedef struct packed {
        logic [7:0] r;
        logic [7:0] g;
        logic [7:0] b;
    } rgb_t;
    typedef struct packed {
        logic [6:0] alpha_prethr;
        logic [6:0] alpha_thr;
        logic [6:0] alpha_depth_m1;
        logic [11:0] alpha_bytes;
        logic [7:0] w3_prethr;
        logic [7:0] w3_thr;
        logic [7:0] w3_depth_m1;
        logic [12:0] w3_bytes;
    } fifo_cfg_t;
    typedef struct packed {
        logic [12:0] pixels;
        logic [1:0] lines;
    } win_count_t;
endpackage : video_overlay_pkg

// file: video_overlay_key_csc_regs.sv
// Purpose: overlay key, fifo, icon and colour conversion registers
// Assumes: pixel inputs come from logic on clk_i
// Notes: avalon-mm slave, one wait cycle per access
//
// Implementation choice: the Avalon-MM slave port.
`timescale 1ns/1ps
`include "video_overlay_cfg.svh"
module video_overlay_key_csc_regs #(
    parameter int ADDR_W = 12
) (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic [ADDR_W-1:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    input wire video_overlay_pkg::gfx_mode_t gfx_mode_i,
    input wire video_overlay_pkg::gfx_mode_t icon_fmt_i,
    input wire logic [29:0] sec_pixel_i,
    input wire logic [23:0] pri_pixel_i,
    input wire logic [29:0] icon_pixel_i,
    input wire logic ycc_valid_i,
    input wire video_overlay_pkg::ycc_t ycc_i,
    output logic sec_show_video_o,
    output logic pri_show_video_o,
    output logic icon_transparent_o,
    output logic icon_inverse_o,
    output logic rgb_valid_o,
    output video_overlay_pkg::rgb_t rgb_o,
    output video_overlay_pkg::fifo_cfg_t fifo_cfg_o,
    output video_overlay_pkg::win_count_t w1_count_o,
    output video_overlay_pkg::win_count_t w3_count_o
);
    // refuse address widths that cannot reach the bank
    if (ADDR_W < 12 || ADDR_W > 32)
    begin : g_check
        $error("ADDR_W must lie between 12 and 32");
    end

    logic [31:0] regs_q [`NUM_REGS];
    video_overlay_pkg::bus_state_t state_q;
    logic wait_q;
    logic [31:0] rdata_q;
    logic [11:0] addr;
    logic [3:0] idx;
    logic hit;
    logic stat_hit;
    logic [31:0] status;
    logic [31:0] be_mask;
    logic req;

    // writable mask per register index
    function automatic logic [31:0] reg_mask(input logic [3:0] i);
        case (i)
            4'h0: reg_mask = `MASK_SEC_KEY;
            4'h1: reg_mask = `MASK_PRETHR;
            4'h2: reg_mask = `MASK_COUNT;
            4'h3: reg_mask = `MASK_ICON;
            4'h4: reg_mask = `MASK_ICON;
            4'h5: reg_mask = `MASK_DEPTH_THR;
            4'h6: reg_mask = `MASK_COUNT;
            4'h7: reg_mask = `MASK_PRI_KEY;
            4'h8: reg_mask = `MASK_CSC_A;
            4'h9: reg_mask = `MASK_CSC_B;
            default: reg_mask = 32'h00000000;
        endcase
    endfunction : reg_mask

    // compare width per colour depth
    function automatic logic [29:0] cmp_mask(
        input video_overlay_pkg::gfx_mode_t m);
        case (m)
            video_overlay_pkg::GM_30: cmp_mask = `CMP_MASK_30;
            video_overlay_pkg::GM_32: cmp_mask = `CMP_MASK_32;
            video_overlay_pkg::GM_565: cmp_mask = `CMP_MASK_565;
            video_overlay_pkg::GM_555: cmp_mask = `CMP_MASK_555;
            default: cmp_mask = `CMP_MASK_8;
        endcase
    endfunction : cmp_mask

    // sign-magnitude, six bits, to two's complement
    function automatic logic signed [6:0] sm6(input logic [5:0] v);
        logic [6:0] mag;
        mag = {2'h0, v[4:0]};
        sm6 = v[5] ? -$signed(mag) : $signed(mag);
    endfunction : sm6

    // sign-magnitude, five bits, to two's complement
    function automatic logic signed [6:0] sm5(input logic [4:0] v);
        logic [6:0] mag;
        mag = {3'h0, v[3:0]};
        sm5 = v[4] ? -$signed(mag) : $signed(mag);
    endfunction : sm5

    // one colour channel: ((A*Y + 2*B*Cb + 2*C*Cr) >>> 4) + D, clamped
    function automatic logic [7:0] chan(
        input logic [4:0] a,
        input logic signed [6:0] b,
        input logic signed [6:0] c,
        input logic signed [7:0] d,
        input video_overlay_pkg::ycc_t p);
        logic signed [17:0] ay;
        logic signed [17:0] bc;
        logic signed [17:0] cc;
        logic signed [17:0] sum;
        ay = $signed({5'h0, 13'(a) * 13'(p.y)}); // full 13-bit product
        bc = 18'(b * p.cb) <<< 1;
        cc = 18'(c * p.cr) <<< 1;
        sum = ((ay + bc + cc) >>> 4) + 18'(d);
        if (sum < 0)
            chan = 8'h00;
        else if (sum > 18'sd255)
            chan = 8'hff;
        else
            chan = sum[7:0];
    endfunction : chan

    // address decode
    assign addr = avs_address_i[11:0];
    assign idx = 4'((addr - `OFS_SEC_KEY) >> 2);
    assign hit = (addr >= `OFS_SEC_KEY) && (addr <= `OFS_CSC_B)
        && (addr[1:0] == 2'h0) && (avs_address_i >> 12 == '0);
    assign stat_hit = (addr == `OFS_STATUS)
        && (avs_address_i >> 12 == '0);
    assign req = avs_read_i | avs_write_i;
    assign be_mask = {{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}},
        {8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};

    // bus handshake: answer one cycle after the request is seen
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            state_q <= video_overlay_pkg::BUS_IDLE;
            wait_q <= 1'b1;
        end
        else
        begin
            case (state_q)
                video_overlay_pkg::BUS_IDLE:
                begin
                    if (req)
                    begin
                        state_q <= video_overlay_pkg::BUS_ACK;
                        wait_q <= 1'b0;
                    end
                end
                video_overlay_pkg::BUS_ACK:
                begin
                    state_q <= video_overlay_pkg::BUS_IDLE;
                    wait_q <= 1'b1;
                end
                default:
                begin
                    state_q <= video_overlay_pkg::BUS_IDLE;
                    wait_q <= 1'b1;
                end
            endcase
        end
    end

    // read data, set while the answer is prepared
    // reserved bits read zero
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
            rdata_q <= 32'h00000000;
        else if (state_q == video_overlay_pkg::BUS_IDLE && avs_read_i)
        begin
            if (hit)
                rdata_q <= regs_q[idx] & reg_mask(idx);
            else if (stat_hit)
                rdata_q <= status;
            else
                rdata_q <= 32'h00000000;
        end
    end

    // register storage, written when the master sees the answer
    // reserved bits ignore writes
    for (genvar i = 0; i < `NUM_REGS; i++)
    begin : g_reg
        always_ff @(posedge clk_i)
        begin
            if (srst_i)
                regs_q[i] <= `RESET_VALUE;
            else if (state_q == video_overlay_pkg::BUS_ACK && avs_write_i
                && hit && idx == 4'(i))
                regs_q[i] <= ((avs_writedata_i & be_mask)
                    | (regs_q[i] & ~be_mask)) & reg_mask(4'(i));
        end
    end

    // key values and controls
    logic [29:0] sec_key;
    logic [29:0] pri_key;
    logic sec_match;
    logic pri_match;
    logic [29:0] sec_cmask;
    logic [29:0] icon_cmask;

    // bit 31 stands in for key bit 29
    assign sec_key = {regs_q[0][`SKEY_HI_BIT], regs_q[0][28:0]};
    assign pri_key = {6'h00, regs_q[7][23:0]};
    assign sec_cmask = cmp_mask(gfx_mode_i);
    assign icon_cmask = cmp_mask(icon_fmt_i);
    assign sec_match = ((sec_pixel_i ^ sec_key) & sec_cmask) == '0;
    assign pri_match = (({6'h00, pri_pixel_i} ^ pri_key)
        & sec_cmask & `CMP_MASK_32) == '0;

    // key decisions; disabled keying leaves video shown
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            sec_show_video_o <= 1'b1;
            pri_show_video_o <= 1'b1;
        end
        else
        begin
            sec_show_video_o <= regs_q[0][`KEY_EN_BIT]
                ? (sec_match ^ regs_q[0][`KEY_INV_BIT]) : 1'b1;
            pri_show_video_o <= regs_q[7][`KEY_EN_BIT]
                ? (pri_match ^ regs_q[7][`KEY_INV_BIT]) : 1'b1;
        end
    end

    // icon colour compares
    // icon colours by icon format
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            icon_transparent_o <= 1'b0;
            icon_inverse_o <= 1'b0;
        end
        else
        begin
            icon_transparent_o <=
                ((icon_pixel_i ^ regs_q[3][29:0]) & icon_cmask) == '0;
            icon_inverse_o <=
                ((icon_pixel_i ^ regs_q[4][29:0]) & icon_cmask) == '0;
        end
    end

    // fifo settings, with byte sizes of each fifo
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
            fifo_cfg_o <= '0;
        else
        begin
            fifo_cfg_o.alpha_prethr <= regs_q[1][22:16];
            fifo_cfg_o.w3_prethr <= regs_q[1][7:0];
            fifo_cfg_o.alpha_thr <= regs_q[5][30:24];
            fifo_cfg_o.w3_thr <= regs_q[5][15:8];
            fifo_cfg_o.alpha_depth_m1 <= regs_q[5][22:16];
            fifo_cfg_o.w3_depth_m1 <= regs_q[5][7:0];
            fifo_cfg_o.alpha_bytes <=
                12'({5'h00, regs_q[5][22:16]} + 12'h001) << `LEVEL_SHIFT;
            fifo_cfg_o.w3_bytes <=
                13'({5'h00, regs_q[5][7:0]} + 13'h0001) << `LEVEL_SHIFT;
        end
    end

    // on-screen counts for both windows
    // pixel field plus one, line field as stored
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            w1_count_o <= '0;
            w3_count_o <= '0;
        end
        else
        begin
            w1_count_o.pixels <= {1'b0, regs_q[2][11:0]} + 13'h0001;
            w1_count_o.lines <= regs_q[2][27:26];
            w3_count_o.pixels <= {1'b0, regs_q[6][11:0]} + 13'h0001;
            w3_count_o.lines <= regs_q[6][27:26];
        end
    end

    // coefficient source: standard preset, high definition, or programmed
    logic [31:0] img_a;
    logic [31:0] img_b;
    logic [4:0] coef_a;
    logic signed [7:0] coef_d;

    // preset selection, standard wins when both set
    always_comb
    begin
        if (regs_q[8][`CSC_SD_BIT])
        begin
            img_a = `CSC_SD_IMG_A;
            img_b = `CSC_SD_IMG_B;
        end
        else if (regs_q[8][`CSC_HD_BIT])
        begin
            img_a = `CSC_HD_IMG_A;
            img_b = `CSC_HD_IMG_B;
        end
        else
        begin
            img_a = regs_q[8];
            img_b = regs_q[9];
        end
    end

    assign coef_a = img_a[28:24];
    assign coef_d = $signed(img_a[7:0]);

    // conversion, one cycle from input to output
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            rgb_valid_o <= 1'b0;
            rgb_o <= '0;
        end
        else
        begin
            rgb_valid_o <= ycc_valid_i;
            if (ycc_valid_i)
            begin
                rgb_o.r <= chan(coef_a, sm6(img_a[21:16]),
                    sm6(img_a[13:8]), coef_d, ycc_i);
                rgb_o.g <= chan(coef_a, sm5(img_b[28:24]),
                    sm5(img_b[20:16]), coef_d, ycc_i);
                rgb_o.b <= chan(coef_a, sm6(img_b[13:8]),
                    sm6(img_b[5:0]), coef_d, ycc_i);
            end
        end
    end

    // status: pre-threshold warnings and live key results
    assign status = {26'h0, regs_q[8][`CSC_SD_BIT] & regs_q[8][`CSC_HD_BIT],
        pri_match, sec_match,
        regs_q[1][7:0] < regs_q[5][15:8],
        regs_q[1][22:16] < regs_q[5][30:24], 1'b0};

    assign avs_readdata_o = rdata_q;
    assign avs_waitrequest_o = wait_q;
endmodule : video_overlay_key_csc_regs

// file: overlay_regs_chk.sv
// Purpose: bus and pixel path checks for the overlay register bank
// Assumes: bound to video_overlay_key_csc_regs
// Notes: keeps a shadow of the secondary key from bus writes
`timescale 1ns/1ps
`include "video_overlay_cfg.svh"
module overlay_regs_chk #(
    parameter int ADDR_W = 12
) (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic [ADDR_W-1:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    input wire logic [31:0] avs_readdata_o,
    input wire logic avs_waitrequest_o,
    input wire video_overlay_pkg::gfx_mode_t gfx_mode_i,
    input wire logic [29:0] sec_pixel_i,
    input wire logic ycc_valid_i,
    input wire logic sec_show_video_o,
    input wire logic rgb_valid_o,
    input wire video_overlay_pkg::fifo_cfg_t fifo_cfg_o
);
    logic [31:0] sec_q;
    logic [29:0] cmp_mask;
    logic sec_exp;
    logic taken;
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (srst_i);
    // request accepted while the slave is idle
    assign taken = (avs_read_i || avs_write_i) && avs_waitrequest_o;
    // shadow of the secondary key, byte lanes merged
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
            sec_q <= '0;
        else if (avs_write_i && !avs_waitrequest_o && avs_address_i == `OFS_SEC_KEY)
            for (int i = 0; i < 4; i++)
                if (avs_byteenable_i[i])
                    sec_q[8*i +: 8] <= avs_writedata_i[8*i +: 8];
    end
    // compare width from the colour depth
    always_comb
    begin
        case (gfx_mode_i)
            video_overlay_pkg::GM_30: cmp_mask = `CMP_MASK_30;
            video_overlay_pkg::GM_32: cmp_mask = `CMP_MASK_32;
            video_overlay_pkg::GM_565: cmp_mask = `CMP_MASK_565;
            video_overlay_pkg::GM_555: cmp_mask = `CMP_MASK_555;
            default: cmp_mask = `CMP_MASK_8;
        endcase
    end
    // expected show-video decision, key bit 29 taken from bit 31
    assign sec_exp = ((((sec_pixel_i ^ {sec_q[31], sec_q[28:0]}) & cmp_mask) == '0) ^ sec_q[`KEY_INV_BIT]);

    wait_one_a: assert property (taken |=> !avs_waitrequest_o)
        else $error("waitrequest not low after request");
    wait_single_a: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
        else $error("waitrequest low for more than one cycle");
    unmapped_rd_a: assert property (avs_read_i && taken && avs_address_i[ADDR_W-1:10] != '0 |=> avs_readdata_o == '0)
        else $error("unmapped read not zero");
    reserved_rd_a: assert property (avs_read_i && taken && avs_address_i == `OFS_PRETHR |=> (avs_readdata_o & ~`MASK_PRETHR) == '0)
        else $error("reserved bits read nonzero");
    rdata_hold_a: assert property (!(avs_read_i && taken) |=> $stable(avs_readdata_o))
        else $error("read data changed without a read");
    sec_off_a: assert property (!sec_q[`KEY_EN_BIT] |=> sec_show_video_o)
        else $error("video hidden with keying off");
    sec_match_a: assert property (sec_q[`KEY_EN_BIT] |=> sec_show_video_o == $past(sec_exp))
        else $error("secondary key decision wrong");
    rgb_on_a: assert property (ycc_valid_i |=> rgb_valid_o)
        else $error("rgb valid missing");
    rgb_off_a: assert property (!ycc_valid_i |=> !rgb_valid_o)
        else $error("rgb valid without pixel");
    alpha_bytes_a: assert property (fifo_cfg_o.alpha_depth_m1 != '0 && $stable(fifo_cfg_o.alpha_depth_m1) |-> fifo_cfg_o.alpha_bytes == {fifo_cfg_o.alpha_depth_m1 + 8'h01, 4'h0})
        else $error("alpha fifo bytes wrong");
    w3_bytes_a: assert property (fifo_cfg_o.w3_depth_m1 != '0 && $stable(fifo_cfg_o.w3_depth_m1) |-> fifo_cfg_o.w3_bytes == {{1'b0, fifo_cfg_o.w3_depth_m1} + 9'h001, 4'h0})
        else $error("window three fifo bytes wrong");

    wr_c: cover property (avs_write_i && !avs_waitrequest_o);
    key_c: cover property (sec_q[`KEY_EN_BIT] && sec_show_video_o);
    rgb_c: cover property (rgb_valid_o);
endmodule : overlay_regs_chk
bind video_overlay_key_csc_regs overlay_regs_chk #(.ADDR_W(ADDR_W)) i_chk (.*);

// file: tb_top.sv
// Purpose: self-checking bench for the overlay register bank
// Assumes: 250 MHz clock, synchronous active-high reset
// Notes: key and conversion cases run from one table
`timescale 1ns/1ps
`include "video_overlay_cfg.svh"
module tb_top;
    typedef struct {
        logic [31:0] sk, pk, ca, cb;
        logic [2:0] m;
        logic [29:0] sp;
        logic [23:0] pp, y;
        logic es, ep;
        logic [23:0] er;
    } row_t;
    logic clk_i = 1'b0;
    logic srst_i = 1'b1;
    logic [11:0] avs_address_i = '0;
    logic avs_read_i = 1'b0;
    logic avs_write_i = 1'b0;
    logic [31:0] avs_writedata_i = '0;
    logic [3:0] avs_byteenable_i = '0;
    logic [31:0] avs_readdata_o;
    logic avs_waitrequest_o;
    video_overlay_pkg::gfx_mode_t gfx_mode_i = video_overlay_pkg::GM_32;
    video_overlay_pkg::gfx_mode_t icon_fmt_i = video_overlay_pkg::GM_32;
    logic [29:0] sec_pixel_i = '0;
    logic [23:0] pri_pixel_i = '0;
    logic [29:0] icon_pixel_i = '0;
    logic ycc_valid_i = 1'b0;
    video_overlay_pkg::ycc_t ycc_i = '0;
    logic sec_show_video_o;
    logic pri_show_video_o;
    logic icon_transparent_o;
    logic icon_inverse_o;
    logic rgb_valid_o;
    video_overlay_pkg::rgb_t rgb_o;
    video_overlay_pkg::fifo_cfg_t fifo_cfg_o;
    video_overlay_pkg::win_count_t w1_count_o;
    video_overlay_pkg::win_count_t w3_count_o;
    int errors = 0;
    int n_compared = 0;
    logic [11:0] ofs[10] = '{`OFS_SEC_KEY, `OFS_PRETHR, `OFS_W1_COUNT, `OFS_ICON_TRANSP, `OFS_ICON_INV,
        `OFS_DEPTH_THR, `OFS_W3_COUNT, `OFS_PRI_KEY, `OFS_CSC_A, `OFS_CSC_B};
    logic [31:0] msk[10] = '{`MASK_SEC_KEY, `MASK_PRETHR, `MASK_COUNT, `MASK_ICON, `MASK_ICON,
        `MASK_DEPTH_THR, `MASK_COUNT, `MASK_PRI_KEY, `MASK_CSC_A, `MASK_CSC_B};
    // key rows first, then conversion rows with keying off
    row_t rows[18] = '{
        '{'0, '0, '0, '0, 3'h2, 30'h1, 24'h1, '0, 1'b1, 1'b1, '0},
        '{32'h40123456, 32'h40abcdef, '0, '0, 3'h2, 30'h123456, 24'habcdef, '0, 1'b1, 1'b1, '0},
        '{32'h40123456, 32'h40abcdef, '0, '0, 3'h2, 30'h923456, 24'h0bcdef, '0, 1'b0, 1'b0, '0},
        '{32'h60123456, 32'h60abcdef, '0, '0, 3'h2, 30'h923456, 24'h0bcdef, '0, 1'b1, 1'b1, '0},
        '{32'h40ff1234, 32'h40ff1234, '0, '0, 3'h3, 30'h1234, 24'h1234, '0, 1'b1, 1'b1, '0},
        '{32'h40ff9234, 32'h40ff9234, '0, '0, 3'h1, 30'h1234, 24'h1234, '0, 1'b1, 1'b1, '0},
        '{32'h40ffff34, 32'h40000034, '0, '0, 3'h0, 30'h34, 24'hffff34, '0, 1'b1, 1'b1, '0},
        '{32'hc0000000, 32'h40000000, '0, '0, 3'h6, 30'h20000000, 24'h0, '0, 1'b1, 1'b1, '0},
        '{32'hc0000000, 32'h40000001, '0, '0, 3'h6, 30'h0, 24'h0, '0, 1'b0, 1'b0, '0},
        '{'0, '0, 32'h10000005, '0, 3'h2, '0, '0, 24'h640000, 1'b1, 1'b1, 24'h696969},
        '{'0, '0, 32'h10080005, '0, 3'h2, '0, '0, 24'h640a00, 1'b1, 1'b1, 24'h736969},
        '{'0, '0, 32'h10280005, '0, 3'h2, '0, '0, 24'h640a00, 1'b1, 1'b1, 24'h5f6969},
        '{'0, '0, 32'h10000005, 32'h08000000, 3'h2, '0, '0, 24'h640a00, 1'b1, 1'b1, 24'h697369},
        '{'0, '0, 32'h10000005, 32'h00000008, 3'h2, '0, '0, 24'h6400f0, 1'b1, 1'b1, 24'h696959},
        '{'0, '0, 32'h1f00007f, '0, 3'h2, '0, '0, 24'hff0000, 1'b1, 1'b1, 24'hffffff},
        '{'0, '0, 32'h00000080, '0, 3'h2, '0, '0, 24'h000000, 1'b1, 1'b1, 24'h000000},
        '{'0, '0, 32'h80000000, '0, 3'h2, '0, '0, 24'h640010, 1'b1, 1'b1, 24'h7d5763},
        '{'0, '0, 32'h40000000, '0, 3'h2, '0, '0, 24'h640010, 1'b1, 1'b1, 24'h7f5b63}
    };

    video_overlay_key_csc_regs i_dut (.*);

    // compare and count
    task automatic chk(input string nm, input logic [79:0] seen, input logic [79:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            errors++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    // one bus access, held until waitrequest is seen low
    task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [3:0] be,
        output logic [31:0] q);
        int n = 0;
        @(posedge clk_i);
        avs_address_i <= a;
        avs_writedata_i <= d;
        avs_byteenable_i <= be;
        avs_write_i <= wr;
        avs_read_i <= !wr;
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (avs_waitrequest_o !== 1'b0 && n < 50);
        q = avs_readdata_o;
        avs_read_i <= 1'b0;
        avs_write_i <= 1'b0;
        if (n >= 50)
        begin
            chk("bus_answer", 1'b0, 1'b1);
            test_done();
        end
    endtask : bus

    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] be);
        logic [31:0] q;
        bus(1'b1, a, d, be, q);
    endtask : wr

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, 4'hf, q);
        chk("readdata", q, e);
    endtask : rd_chk

    // icon pixel against both icon colours
    task automatic icon(input logic [2:0] f, input logic [29:0] p, input logic et, input logic ei);
        @(posedge clk_i);
        icon_fmt_i <= video_overlay_pkg::gfx_mode_t'(f);
        icon_pixel_i <= p;
        @(posedge clk_i);
        #1;
        chk("icon_transparent", icon_transparent_o, et); // transparent
        chk("icon_inverse", icon_inverse_o, ei); // inverse
    endtask : icon

    task automatic test_done();
        $display("compared %0d errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : test_done

    // free-running clock
    initial
    begin
        forever #2 clk_i = ~clk_i;
    end

    // hang guard
    initial
    begin
        #40000;
        errors++;
        test_done();
    end

    // main sequence
    initial
    begin
        repeat (8) @(posedge clk_i);
        srst_i <= 1'b0;
        @(posedge clk_i);
        #1;
        chk("waitrequest", avs_waitrequest_o, 1'b1);
        chk("sec_show", sec_show_video_o, 1'b1); // keying off
        foreach (ofs[i])
        begin
            rd_chk(ofs[i], 32'h0); // reset value
            wr(ofs[i], 32'hffffffff, 4'hf);
            rd_chk(ofs[i], msk[i]); // reserved bits
        end
        wr(12'h28c, 32'hffffffff, 4'hf);
        rd_chk(12'h28c, 32'h0); // unmapped
        rd_chk(12'h265, 32'h0); // misaligned
        rd_chk(12'hc64, 32'h0); // unmapped high address
        wr(`OFS_SEC_KEY, 32'h12345678, 4'hf);
        wr(`OFS_SEC_KEY, 32'hffffffff, 4'h2);
        rd_chk(`OFS_SEC_KEY, 32'h1234ff78); // lane merge
        wr(`OFS_DEPTH_THR, 32'h05030702, 4'hf);
        wr(`OFS_PRETHR, 32'h00060009, 4'hf);
        repeat (2) @(posedge clk_i);
        #1;
        chk("fifo_cfg", fifo_cfg_o, {7'd6, 7'd5, 7'd3, 12'd64, 8'd9, 8'd7, 8'd2, 13'd48}); // fields
        rd_chk(`OFS_STATUS, 32'h00000020); // both preset bits flagged
        wr(`OFS_DEPTH_THR, 32'h007f00ff, 4'hf);
        repeat (2) @(posedge clk_i);
        #1;
        chk("alpha_bytes", fifo_cfg_o.alpha_bytes, 12'd2048); // largest depth
        chk("w3_bytes", fifo_cfg_o.w3_bytes, 13'd4096); // largest depth
        wr(`OFS_W1_COUNT, 32'h0c0000ff, 4'hf);
        wr(`OFS_W3_COUNT, 32'h04000fff, 4'hf);
        repeat (2) @(posedge clk_i);
        #1;
        chk("w1_count", w1_count_o, {13'd256, 2'd3}); // count plus one
        chk("w3_count", w3_count_o, {13'd4096, 2'd1}); // count plus one
        wr(`OFS_ICON_TRANSP, 32'h3fabcdef, 4'hf);
        wr(`OFS_ICON_INV, 32'h00001234, 4'hf);
        icon(3'h2, 30'h00abcdef, 1'b1, 1'b0);
        icon(3'h3, 30'h3fff1234, 1'b0, 1'b1);
        icon(3'h1, 30'h3fff9234, 1'b0, 1'b1);
        icon(3'h6, 30'h3fabcdef, 1'b1, 1'b0);
        icon(3'h6, 30'h00abcdef, 1'b0, 1'b0);
        foreach (rows[i])
        begin
            wr(`OFS_SEC_KEY, rows[i].sk, 4'hf);
            wr(`OFS_PRI_KEY, rows[i].pk, 4'hf);
            wr(`OFS_CSC_A, rows[i].ca, 4'hf);
            wr(`OFS_CSC_B, rows[i].cb, 4'hf);
            @(posedge clk_i);
            gfx_mode_i <= video_overlay_pkg::gfx_mode_t'(rows[i].m);
            sec_pixel_i <= rows[i].sp;
            pri_pixel_i <= rows[i].pp;
            ycc_i <= rows[i].y;
            ycc_valid_i <= 1'b1;
            @(posedge clk_i);
            #1;
            chk("sec_show", sec_show_video_o, rows[i].es); // secondary key
            chk("pri_show", pri_show_video_o, rows[i].ep); // primary key
            chk("rgb", rgb_o, rows[i].er); // conversion
            chk("rgb_valid", rgb_valid_o, 1'b1);
        end
        @(posedge clk_i);
        srst_i <= 1'b1;
        ycc_valid_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        srst_i <= 1'b0;
        rd_chk(`OFS_CSC_A, 32'h0); // cleared by reset
        rd_chk(`OFS_PRI_KEY, 32'h0); // cleared by reset
        test_done();
    end
endmodule : tb_top
